// >>> core/motion_status_map.svh
`ifndef MOTION_STATUS_MAP_SVH
`define MOTION_STATUS_MAP_SVH

// ----------------------------------------
// Register byte offsets (low address byte)
// ----------------------------------------
`define OFF_DRIVE_STATUS_FIRST 8'h00
`define OFF_DRIVE_STATUS_SECOND 8'h04
`define OFF_EXTENSION_BOARD_STATUS 8'h08
`define OFF_CAPTURE_POSITION 8'h0C
`define OFF_USER_BITS_PARAM 8'h10
`define OFF_CAPTURE_REARM_PARAM 8'h14
`define OFF_CAPTURE_INPUT_SELECT_PARAM 8'h18
`define OFF_CAPTURE_EDGE_PARAM 8'h1C
`define OFF_SEQUENCE_EDIT_COMMAND 8'h20
`define OFF_SEQUENCE_PROGRAM 8'h24
`define ADDR_HIGH_ZERO 24'h00_0000

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FIRST_SEQ_RUN_BIT 8
`define FIRST_EDIT_MODE_BIT 9
`define FIRST_ERROR_BIT 10
`define FIRST_TRACE_BUSY_BIT 11
`define FIRST_HOMING_BIT 13
`define FIRST_WARNING_BIT 23
`define SECOND_SEQ_ERR_BIT 0
`define SECOND_CAPTURE_BIT 2
`define SECOND_USER_LSB 8
`define EXT_USER_WIDTH 9
`define EXT_PRESENT_BIT 19

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SECOND_RESET 32'h0000_0000
`define EXT_RESET 32'h0008_0000
`define USER_WORD_RESET 16'h0000
`define SEQ_PROG_RESET 32'h0000_0000

`endif

// >>> core/motion_status_pkg.sv
package motion_status_pkg;

  // ----------------------------------------
  // Internal controller state flags
  // ----------------------------------------
  typedef struct packed {
    logic seq_running;
    logic error_state;
    logic trace_busy;
    logic homing;
    logic warning;
    logic seq_err_pending;
  } drive_state_s;

  // ----------------------------------------
  // Capture edge selection
  // ----------------------------------------
  typedef enum logic [1:0] {
    CAP_RISE = 2'b00,
    CAP_FALL = 2'b01,
    CAP_BOTH = 2'b10
  } cap_edge_e;

endpackage : motion_status_pkg

// >>> core/user_word_reg.sv
`timescale 1ns/10ps
`include "motion_status_map.svh"

module user_word_reg #(
  parameter int WIDTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] load_data_i,
  input wire logic [WIDTH-1:0] set_i,
  input wire logic [WIDTH-1:0] clr_i,
  output logic [WIDTH-1:0] word_o
);

  typedef struct packed {
    logic [WIDTH-1:0] word;
  } user_state_s;

  user_state_s st;
  user_state_s next_st;

  // Parameter load, then trigger clear, then trigger set
  always_comb begin
    next_st = st;
    if (load_i) begin
      next_st.word = load_data_i;
    end
    next_st.word = (next_st.word & ~clr_i) | set_i;
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= user_state_s'(WIDTH'(`USER_WORD_RESET));
    end else begin
      st <= next_st;
    end
  end

  assign word_o = st.word;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_user_trigger;
    (set_i != '0) |=> ((word_o & $past(set_i)) == $past(set_i));
  endproperty
  a_user_trigger: assert property (p_user_trigger) else $error("trigger set lost");

endmodule : user_word_reg

// >>> core/motion_drive_status_bits.sv
// Function
// - First status bit 8 high while an internal sequence executes.
// - First status bit 9 shows edit mode; program writes only then.
// - First status bit 10 high while in error state.
// - First status bit 11 high during trace acquisition, low otherwise.
// - First status bit 13 high while homing is in progress.
// - Second status bit 0 high while a sequence error label waits.
// - Second status bit 2 set on capture; cleared by writing one to re-arm.
// - Second status bits 8 to 15 show user bits 0 to 7.
// - Extension status bits 0 to 8 mirror user word bits 0 to 8.
//
// Added by the designer: the AHB-Lite register port and the register addresses.
`timescale 1ns/10ps
`include "motion_status_map.svh"

module motion_drive_status_bits #(
  parameter int DIN_WIDTH = 10,
  parameter int USER_WIDTH = 16
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire motion_status_pkg::drive_state_s drive_state_i,
  input wire logic [DIN_WIDTH-1:0] din_i,
  input wire logic [31:0] position_i,
  input wire logic [USER_WIDTH-1:0] trig_set_i,
  input wire logic [USER_WIDTH-1:0] trig_clr_i,
  output logic edit_mode_o,
  output logic capture_flag_o,
  output logic [31:0] seq_prog_o,
  output logic [USER_WIDTH-1:0] user_word_o
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic edit_mode;
    logic cap_flag;
    logic [31:0] cap_pos;
    logic [3:0] cap_sel;
    logic [1:0] cap_edge;
    logic [31:0] seq_prog;
    logic [DIN_WIDTH-1:0] din_s1;
    logic [DIN_WIDTH-1:0] din_s2;
    logic [DIN_WIDTH-1:0] din_d;
  } core_state_s;

  core_state_s st;
  core_state_s next_st;

  logic addr_phase;
  logic [7:0] addr_lo;
  logic addr_ok;
  logic user_load;
  logic rearm;
  logic edge_hit;
  logic [31:0] first_word;
  logic [31:0] second_word;
  logic [31:0] ext_word;
  logic [31:0] read_word;
  logic sel_din_now;
  logic sel_din_old;
  logic [2:0] unused_size;

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  // Address phase accepted while the bus is ready
  assign addr_phase = hsel_i & hready_i & htrans_i[1];
  assign addr_lo = haddr_i[7:0];
  assign addr_ok = (haddr_i[31:8] == `ADDR_HIGH_ZERO) & (haddr_i[1:0] == 2'h0);
  assign unused_size = hsize_i;

  // Data phase effects of a write
  assign user_load = st.wr_pend & (st.wr_addr == `OFF_USER_BITS_PARAM);
  assign rearm = st.wr_pend & (st.wr_addr == `OFF_CAPTURE_REARM_PARAM) & hwdata_i[0];

  // ----------------------------------------
  // Status word assembly
  // ----------------------------------------
  // First status word
  always_comb begin
    first_word = 32'h0000_0000;
    first_word[`FIRST_SEQ_RUN_BIT] = drive_state_i.seq_running;
    first_word[`FIRST_EDIT_MODE_BIT] = st.edit_mode;
    first_word[`FIRST_ERROR_BIT] = drive_state_i.error_state;
    first_word[`FIRST_TRACE_BUSY_BIT] = drive_state_i.trace_busy;
    first_word[`FIRST_HOMING_BIT] = drive_state_i.homing;
    first_word[`FIRST_WARNING_BIT] = drive_state_i.warning;
  end

  // Second status word
  always_comb begin
    second_word = `SECOND_RESET;
    second_word[`SECOND_SEQ_ERR_BIT] = drive_state_i.seq_err_pending;
    second_word[`SECOND_CAPTURE_BIT] = st.cap_flag;
    second_word[`SECOND_USER_LSB +: 8] = user_word_o[7:0];
  end

  // Extension board status word
  always_comb begin
    ext_word = `EXT_RESET;
    ext_word[`EXT_USER_WIDTH-1:0] = user_word_o[`EXT_USER_WIDTH-1:0];
  end

  // Read multiplexer, unmapped reads return zero
  always_comb begin
    read_word = 32'h0000_0000;
    if (addr_ok) begin
      case (addr_lo)
        `OFF_DRIVE_STATUS_FIRST: read_word = first_word;
        `OFF_DRIVE_STATUS_SECOND: read_word = second_word;
        `OFF_EXTENSION_BOARD_STATUS: read_word = ext_word;
        `OFF_CAPTURE_POSITION: read_word = st.cap_pos;
        `OFF_USER_BITS_PARAM: read_word = 32'(user_word_o);
        `OFF_CAPTURE_INPUT_SELECT_PARAM: read_word = 32'(st.cap_sel);
        `OFF_CAPTURE_EDGE_PARAM: read_word = 32'(st.cap_edge);
        `OFF_SEQUENCE_EDIT_COMMAND: read_word = 32'(st.edit_mode);
        `OFF_SEQUENCE_PROGRAM: read_word = st.seq_prog;
        default: read_word = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Capture input edge detect
  // ----------------------------------------
  // Selected input after synchroniser, and its previous value
  always_comb begin
    sel_din_now = 1'b0;
    sel_din_old = 1'b0;
    if (32'(st.cap_sel) < DIN_WIDTH) begin
      sel_din_now = st.din_s2[st.cap_sel];
      sel_din_old = st.din_d[st.cap_sel];
    end
  end

  // Edge qualified by the edge parameter; spare code never captures
  always_comb begin
    case (motion_status_pkg::cap_edge_e'(st.cap_edge))
      motion_status_pkg::CAP_RISE: edge_hit = sel_din_now & ~sel_din_old;
      motion_status_pkg::CAP_FALL: edge_hit = ~sel_din_now & sel_din_old;
      motion_status_pkg::CAP_BOTH: edge_hit = sel_din_now ^ sel_din_old;
      default: edge_hit = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // Zero wait state, always OKAY
    next_st.hreadyout = 1'b1;
    next_st.hresp = 1'b0;
    // Pin synchroniser and edge history
    next_st.din_s1 = din_i;
    next_st.din_s2 = st.din_s1;
    next_st.din_d = st.din_s2;
    // Address phase: capture write target or load read data
    if (addr_phase) begin
      next_st.wr_pend = hwrite_i & addr_ok;
      next_st.wr_addr = addr_lo;
      next_st.hrdata = hwrite_i ? 32'h0000_0000 : read_word;
    end else begin
      next_st.wr_pend = 1'b0;
    end
    // Data phase write; status words have no case and are left alone
    // status writes ignored
    if (st.wr_pend) begin
      case (st.wr_addr)
        `OFF_CAPTURE_INPUT_SELECT_PARAM: next_st.cap_sel = hwdata_i[3:0];
        `OFF_CAPTURE_EDGE_PARAM: next_st.cap_edge = hwdata_i[1:0];
        `OFF_SEQUENCE_EDIT_COMMAND: next_st.edit_mode = hwdata_i[0];
        `OFF_SEQUENCE_PROGRAM: begin
          if (st.edit_mode) begin
            next_st.seq_prog = hwdata_i;
          end
        end
        default: begin
        end
      endcase
    end
    if (rearm) begin
      next_st.cap_flag = 1'b0;
    end
    if (edge_hit && (!st.cap_flag || rearm)) begin
      next_st.cap_flag = 1'b1;
      next_st.cap_pos = position_i;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.hreadyout <= 1'b1;
      st.seq_prog <= `SEQ_PROG_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // User word
  // ----------------------------------------
  // user bits storage
  user_word_reg #(
    .WIDTH(USER_WIDTH)
  ) u_user_word (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .load_i(user_load),
    .load_data_i(hwdata_i[USER_WIDTH-1:0]),
    .set_i(trig_set_i),
    .clr_i(trig_clr_i),
    .word_o(user_word_o)
  );

  // Outputs from flops
  assign hrdata_o = st.hrdata;
  assign hreadyout_o = st.hreadyout;
  assign hresp_o = st.hresp;
  assign edit_mode_o = st.edit_mode;
  assign capture_flag_o = st.cap_flag;
  assign seq_prog_o = st.seq_prog;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  logic rd_first;
  logic rd_second;
  logic rd_ext;
  logic wr_status;
  assign rd_first = addr_phase & ~hwrite_i & addr_ok & (addr_lo == `OFF_DRIVE_STATUS_FIRST);
  assign rd_second = addr_phase & ~hwrite_i & addr_ok & (addr_lo == `OFF_DRIVE_STATUS_SECOND);
  assign rd_ext = addr_phase & ~hwrite_i & addr_ok & (addr_lo == `OFF_EXTENSION_BOARD_STATUS);
  assign wr_status = addr_phase & hwrite_i & addr_ok & (addr_lo <= `OFF_EXTENSION_BOARD_STATUS);

  property p_seq_run;
    rd_first |=> hrdata_o[`FIRST_SEQ_RUN_BIT] == $past(drive_state_i.seq_running);
  endproperty
  a_seq_run: assert property (p_seq_run) else $error("sequence bit wrong");

  property p_edit_lock;
    (addr_phase && hwrite_i && addr_ok && addr_lo == `OFF_SEQUENCE_PROGRAM) ##1 !edit_mode_o
      |=> seq_prog_o == $past(seq_prog_o);
  endproperty
  a_edit_lock: assert property (p_edit_lock) else $error("program written outside edit mode");

  property p_error_bit;
    rd_first ##1 1'b1 |-> hrdata_o[`FIRST_ERROR_BIT] == $past(drive_state_i.error_state);
  endproperty
  a_error_bit: assert property (p_error_bit) else $error("error bit wrong");

  property p_trace_bit;
    (rd_first && !drive_state_i.trace_busy) |=> !hrdata_o[`FIRST_TRACE_BUSY_BIT];
  endproperty
  a_trace_bit: assert property (p_trace_bit) else $error("trace bit high when idle");

  property p_homing_bit;
    (rd_first && drive_state_i.homing) |=> hrdata_o[`FIRST_HOMING_BIT];
  endproperty
  a_homing_bit: assert property (p_homing_bit) else $error("homing bit low");

  property p_seq_err;
    rd_second |=> hrdata_o[`SECOND_SEQ_ERR_BIT] == $past(drive_state_i.seq_err_pending);
  endproperty
  a_seq_err: assert property (p_seq_err) else $error("label pending bit wrong");

  property p_cap_hold;
    (capture_flag_o && !rearm) |=> capture_flag_o;
  endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture flag dropped without re-arm");

  property p_cap_set;
    (edge_hit && !capture_flag_o) |=> capture_flag_o && (st.cap_pos == $past(position_i));
  endproperty
  a_cap_set: assert property (p_cap_set) else $error("capture not latched");

  property p_user_field;
    rd_second |=> hrdata_o[`SECOND_USER_LSB +: 8] == $past(user_word_o[7:0]);
  endproperty
  a_user_field: assert property (p_user_field) else $error("user field wrong");

  property p_ext_mirror;
    rd_ext |=> hrdata_o[`EXT_USER_WIDTH-1:0] == $past(user_word_o[`EXT_USER_WIDTH-1:0])
      && hrdata_o[`EXT_PRESENT_BIT];
  endproperty
  a_ext_mirror: assert property (p_ext_mirror) else $error("extension mirror wrong");

  property p_status_wr;
    wr_status |=> ##1 $stable(edit_mode_o) && $stable(seq_prog_o) && !hresp_o;
  endproperty
  a_status_wr: assert property (p_status_wr) else $error("status write had effect");

  // Main scenarios
  c_capture: cover property (edge_hit ##1 capture_flag_o);
  c_rearm: cover property (capture_flag_o && rearm);
  c_edit_write: cover property (st.wr_pend && st.wr_addr == `OFF_SEQUENCE_PROGRAM && edit_mode_o);
  c_read_first: cover property (rd_first ##1 hrdata_o != 32'h0000_0000);

endmodule : motion_drive_status_bits

// >>> test/motion_drive_status_bits_bench.sv
`timescale 1ns/10ps
`include "motion_status_map.svh"

module motion_drive_status_bits_bench;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic ref_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0000_0000;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [2:0] hsize_i = 3'h2;
  logic [31:0] hwdata_i = 32'h0000_0000;
  logic [31:0] hrdata_o;
  logic hreadyout_o;
  logic hresp_o;
  motion_status_pkg::drive_state_s drive_state_i = '0;
  motion_status_pkg::drive_state_s ds = '0;
  logic [9:0] din_i = 10'h000;
  logic [31:0] position_i = 32'h0000_0000;
  logic [15:0] trig_set_i = 16'h0000;
  logic [15:0] trig_clr_i = 16'h0000;
  logic edit_mode_o;
  logic capture_flag_o;
  logic [31:0] seq_prog_o;
  logic [15:0] user_word_o;
  logic [15:0] user_exp = 16'h0000;
  logic [31:0] pos_exp;
  logic [31:0] val;
  logic [31:0] rd;
  logic [7:0] stat_off [3] = '{`OFF_DRIVE_STATUS_FIRST, `OFF_DRIVE_STATUS_SECOND, `OFF_EXTENSION_BOARD_STATUS};
  logic cap;
  int error_cnt = 0;
  int tests_run = 0;
  int sel;

  // Clock generation
  always #50 ref_clk_i = ~ref_clk_i;

  motion_drive_status_bits #(.DIN_WIDTH(10), .USER_WIDTH(16)) motion_drive_status_bits_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
    .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .drive_state_i(drive_state_i),
    .din_i(din_i), .position_i(position_i), .trig_set_i(trig_set_i), .trig_clr_i(trig_clr_i),
    .edit_mode_o(edit_mode_o), .capture_flag_o(capture_flag_o), .seq_prog_o(seq_prog_o),
    .user_word_o(user_word_o)
  );

  // ----------------------------------------
  // Expected status words
  // ----------------------------------------
  function automatic logic [31:0] first_exp(motion_status_pkg::drive_state_s s, logic edit);
    logic [31:0] v;
    v = 32'h0000_0000;
    v[8] = s.seq_running;
    v[9] = edit;
    v[10] = s.error_state;
    v[11] = s.trace_busy;
    v[13] = s.homing;
    v[23] = s.warning;
    return v;
  endfunction : first_exp

  function automatic logic [31:0] second_exp(motion_status_pkg::drive_state_s s, logic c, logic [15:0] u);
    return {16'h0000, u[7:0], 5'h00, c, 1'b0, s.seq_err_pending};
  endfunction : second_exp

  function automatic logic [31:0] ext_exp(logic [15:0] u);
    return 32'h0008_0000 | {23'h00_0000, u[8:0]};
  endfunction : ext_exp

  // ----------------------------------------
  // Checking and bus tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // One single transfer; called right after a rising edge
  task automatic bus(input logic wr, input logic [7:0] off, input logic [31:0] wdata, output logic [31:0] rdata);
    hsel_i <= 1'b1;
    haddr_i <= {`ADDR_HIGH_ZERO, off};
    htrans_i <= 2'h2;
    hwrite_i <= wr;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    hsel_i <= 1'b0;
    htrans_i <= 2'h0;
    hwdata_i <= wdata;
    do @(posedge ref_clk_i); while (hreadyout_o !== 1'b1);
    rdata = hrdata_o;
    check({31'h0000_0000, hresp_o}, 32'h0000_0000, "response");
  endtask : bus

  task automatic wr(input logic [7:0] off, input logic [31:0] data);
    logic [31:0] dummy;
    bus(1'b1, off, data, dummy);
  endtask : wr

  task automatic rdchk(input logic [7:0] off, input logic [31:0] exp, input string what);
    logic [31:0] d;
    bus(1'b0, off, 32'h0000_0000, d);
    check(d, exp, what);
  endtask : rdchk

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : wrap_up

  // Watchdog against a hung bus
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    error_cnt++;
    $display("Error at %0t: watchdog expired", $time);
    wrap_up();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rd = $urandom(52747);
    pos_exp = $urandom;
    position_i <= pos_exp;
    repeat (12) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    rdchk(`OFF_DRIVE_STATUS_SECOND, second_exp(ds, 1'b0, 16'h0000), "second reset");
    rdchk(`OFF_EXTENSION_BOARD_STATUS, ext_exp(16'h0000), "ext reset");
    for (int i = 0; i < 24; i++) begin
      ds = (i == 0) ? 6'h3F : 6'($urandom);
      drive_state_i <= ds;
      rdchk(`OFF_DRIVE_STATUS_FIRST, first_exp(ds, 1'b0), "first word");
      rdchk(`OFF_DRIVE_STATUS_SECOND, second_exp(ds, 1'b0, user_exp), "second word");
    end
    for (int i = 0; i < 3; i++) begin
      wr(stat_off[i], $urandom);
    end
    rdchk(`OFF_DRIVE_STATUS_FIRST, first_exp(ds, 1'b0), "first after write");
    rdchk(`OFF_DRIVE_STATUS_SECOND, second_exp(ds, 1'b0, user_exp), "second after write");
    rdchk(`OFF_EXTENSION_BOARD_STATUS, ext_exp(user_exp), "ext after write");
    wr(8'h40, $urandom);
    rdchk(8'h40, 32'h0000_0000, "unmapped");
    val = $urandom;
    wr(`OFF_SEQUENCE_EDIT_COMMAND, 32'h0000_0001);
    rdchk(`OFF_DRIVE_STATUS_FIRST, first_exp(ds, 1'b1), "edit bit on");
    check({31'h0000_0000, edit_mode_o}, 32'h0000_0001, "edit output");
    wr(`OFF_SEQUENCE_PROGRAM, val);
    rdchk(`OFF_SEQUENCE_PROGRAM, val, "program write");
    wr(`OFF_SEQUENCE_EDIT_COMMAND, 32'h0000_0000);
    wr(`OFF_SEQUENCE_PROGRAM, ~val);
    rdchk(`OFF_SEQUENCE_PROGRAM, val, "program locked");
    check(seq_prog_o, val, "program output");
    rdchk(`OFF_DRIVE_STATUS_FIRST, first_exp(ds, 1'b0), "edit bit off");
    // user bits by parameter and triggers
    for (int i = 0; i < 8; i++) begin
      user_exp = (i == 0) ? 16'hFFFF : 16'($urandom);
      wr(`OFF_USER_BITS_PARAM, {16'h0000, user_exp});
      rdchk(`OFF_DRIVE_STATUS_SECOND, second_exp(ds, 1'b0, user_exp), "user bits");
      rdchk(`OFF_EXTENSION_BOARD_STATUS, ext_exp(user_exp), "ext user bits");
      val = $urandom;
      trig_set_i <= val[15:0];
      trig_clr_i <= val[31:16];
      @(posedge ref_clk_i);
      trig_set_i <= 16'h0000;
      trig_clr_i <= 16'h0000;
      user_exp = (user_exp & ~val[31:16]) | val[15:0];
      rdchk(`OFF_DRIVE_STATUS_SECOND, second_exp(ds, 1'b0, user_exp), "trigger bits");
      rdchk(`OFF_EXTENSION_BOARD_STATUS, ext_exp(user_exp), "ext trigger bits");
      check({16'h0000, user_word_o}, {16'h0000, user_exp}, "user word");
    end
    // capture per edge mode, re-arm clears
    sel = $urandom_range(9, 0);
    wr(`OFF_CAPTURE_INPUT_SELECT_PARAM, sel);
    for (int m = 0; m < 4; m++) begin
      wr(`OFF_CAPTURE_EDGE_PARAM, m);
      wr(`OFF_CAPTURE_REARM_PARAM, 32'h0000_0001);
      din_i[sel] <= 1'b1;
      repeat (5) @(posedge ref_clk_i);
      cap = (m == 0 || m == 2);
      rdchk(`OFF_DRIVE_STATUS_SECOND, second_exp(ds, cap, user_exp), "rise capture");
      check({31'h0000_0000, capture_flag_o}, {31'h0000_0000, cap}, "capture flag");
      if (m == 0) begin
        position_i <= ~pos_exp;
        rdchk(`OFF_CAPTURE_POSITION, pos_exp, "captured position");
        wr(`OFF_CAPTURE_REARM_PARAM, 32'h0000_0000);
        rdchk(`OFF_DRIVE_STATUS_SECOND, second_exp(ds, 1'b1, user_exp), "flag kept");
      end
      wr(`OFF_CAPTURE_REARM_PARAM, 32'h0000_0001);
      rdchk(`OFF_DRIVE_STATUS_SECOND, second_exp(ds, 1'b0, user_exp), "flag re-armed");
      din_i[sel] <= 1'b0;
      repeat (5) @(posedge ref_clk_i);
      cap = (m == 1 || m == 2);
      rdchk(`OFF_DRIVE_STATUS_SECOND, second_exp(ds, cap, user_exp), "fall capture");
      wr(`OFF_CAPTURE_REARM_PARAM, 32'h0000_0001);
    end
    wrap_up();
  end
endmodule : motion_drive_status_bits_bench
